//--- core/ciopl_defines.svh
// Register map, reset values and field positions of the port logic.
// Included by the filter and port logic modules; definitions only.
`ifndef CIOPL_DEFINES_SVH
`define CIOPL_DEFINES_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
// Ports 0..3 each own a 16-byte block: haddr[5:4] picks the port
`define CIOPL_PORT_BLOCK_SEL 2'b00
`define CIOPL_SUB_LATCH 2'h0
`define CIOPL_SUB_CFG_A 2'h1
`define CIOPL_SUB_CFG_B 2'h2
`define CIOPL_SUB_PINS 2'h3
`define CIOPL_OFS_P0_LATCH 8'h00
`define CIOPL_OFS_DIG_IN_DIS 8'h40
`define CIOPL_OFS_USER_CFG1 8'h44

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define CIOPL_RST_LATCH 8'hFF
`define CIOPL_RST_CFG_A 8'hFF
`define CIOPL_RST_CFG_B 8'h00
`define CIOPL_RST_DIG_IN_DIS 8'h00
`define CIOPL_DIG_IN_DIS_MASK 8'h3E
`define CIOPL_RPE_BIT 6
`define CIOPL_USER_CFG1_MASK 8'h40
// Port 1 pins whose configuration is pinned
`define CIOPL_P1_FORCE_A 8'h2C
`define CIOPL_P1_CLEAR_B 8'h20
`define CIOPL_P1_RESET_PIN 5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CIOPL_CLK_MHZ 50
`define CIOPL_GLITCH_NS 40
`define CIOPL_GLITCH_CYC ((`CIOPL_GLITCH_NS * `CIOPL_CLK_MHZ + 999) / 1000)

`endif

//--- core/ciopl_pkg.sv
// Types shared by the port logic modules.
// Assumes the defines header sits beside it.
package ciopl_pkg;

    // Drive type, coded as {cfg_a bit, cfg_b bit}
    typedef enum logic [1:0] {
        CIOPL_QUASI = 2'h0,
        CIOPL_PUSH_PULL = 2'h1,
        CIOPL_INPUT_ONLY = 2'h2,
        CIOPL_OPEN_DRAIN = 2'h3
    } ciopl_mode_t;

    // Bus slave states, one-hot
    typedef enum logic [3:0] {
        CIOPL_ST_IDLE = 4'h1,
        CIOPL_ST_WRITE = 4'h2,
        CIOPL_ST_RD_LOAD = 4'h4,
        CIOPL_ST_RD_DONE = 4'h8
    } ciopl_bus_state_t;

    // Drive of one pad
    typedef struct packed {
        logic strong_oe;
        logic strong_out;
        logic weak_pullup;
    } ciopl_pin_drive_t;

    // Captured AHB address phase
    typedef struct packed {
        logic [7:0] addr;
        logic write;
    } ciopl_ahb_req_t;

endpackage

//--- core/ciopl_pin_filter.sv
// Input conditioner of one pad: three-stage synchroniser plus glitch
// filter. Assumes an asynchronous pad level and one clock domain.
`timescale 1ns/1ps
`include "ciopl_defines.svh"

module ciopl_pin_filter #(
    parameter int FILTER_LEN = `CIOPL_GLITCH_CYC,
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin_async,
    output logic pin_clean
);
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic [7:0] stable_cnt;
    wire agree = (sync_b == sync_c);
    wire differs = agree && (sync_c != pin_clean);
    wire settled = (stable_cnt >= 8'(FILTER_LEN - 1));

    // ------------------------------------------------------------
    // Synchroniser; only sync_b reads sync_a
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= RESET_LEVEL; // Idle level: no false edge
            sync_b <= RESET_LEVEL;
            sync_c <= RESET_LEVEL;
        end else begin
            sync_a <= pin_async;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // Pulses shorter than the filter length never reach the core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stable_cnt <= 8'h00;
            pin_clean <= RESET_LEVEL;
        end else if (!differs) begin
            stable_cnt <= 8'h00;
        end else if (settled) begin
            stable_cnt <= 8'h00;
            pin_clean <= sync_c; // R9
        end else begin
            stable_cnt <= stable_cnt + 8'h01;
        end
    end

endmodule // ciopl_pin_filter

//--- core/ciopl_port_logic.sv
// Configurable I/O port logic: four ports, per-pin drive type, port
// latches, digital input disable and reset-pin selection, all behind
// an AHB-Lite slave.
// Assumes the pads resolve strong drive, weak pull-up and external
// levels; the chip reset logic consumes ext_reset_n.
// Assumes hready is this slave's own hreadyout, the only slave.
//
// Function
// R1: Four ports of 8, 8, 5, 2 bits.
// R2: Each pin picks drive type via two registers.
// R3: Port 1 bit 5 always input, unconfigurable.
// R4: Port 1 bits 2,3 input-only or open-drain.
// R5: Quasi: latch one weak high, zero strong low.
// R6: Open-drain: no pull-up, pull-down when latch zero.
// R7: Input-only: no drivers enabled, pin floats.
// R8: Push-pull: strong high while latch holds one.
// R9: Every input passes synchroniser and glitch filter.
// R10: Analog pins disable output via input-only drive.
// R11: Port 0 bits 1..5 disable digital inputs.
// R12: Those disable bits clear on every reset.
// R13: All pins input-only after power-up.
// R14: Reset-pin enable makes port1 bit5 reset input.
// R15: Codes: 00 quasi, 01 push, 10 input, 11 open-drain.
`timescale 1ns/1ps
`include "ciopl_defines.svh"

module ciopl_port_logic
    import ciopl_pkg::*;
#(
    parameter int P0_WIDTH = 8,
    parameter int P1_WIDTH = 8,
    parameter int P2_WIDTH = 5,
    parameter int P3_WIDTH = 2,
    parameter logic RPE_DEFAULT = 1'b0,
    parameter int FILTER_LEN = `CIOPL_GLITCH_CYC,
    parameter int PIN_COUNT = P0_WIDTH + P1_WIDTH + P2_WIDTH + P3_WIDTH
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe,
    output logic [PIN_COUNT-1:0] pin_weak_pullup,
    output logic ext_reset_n
);

    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int PW [4] = '{P0_WIDTH, P1_WIDTH, P2_WIDTH, P3_WIDTH}; // R1
    // First index of each port in the pin vectors
    localparam int PBASE [4] = '{0, P0_WIDTH, P0_WIDTH + P1_WIDTH,
        P0_WIDTH + P1_WIDTH + P2_WIDTH};

    // Implemented bits of each port; absent bits stay zero
    localparam logic [7:0] PMASK [4] = '{
        8'((9'h001 << P0_WIDTH) - 9'h001),
        8'((9'h001 << P1_WIDTH) - 9'h001),
        8'((9'h001 << P2_WIDTH) - 9'h001),
        8'((9'h001 << P3_WIDTH) - 9'h001)
    }; // R1

    // Port 1 codes held by hardware: bit 5 input-only,
    // bits 2 and 3 never drive high
    localparam logic [7:0] FORCE_A [4] = '{8'h00, `CIOPL_P1_FORCE_A,
        8'h00, 8'h00};
    localparam logic [7:0] CLEAR_B [4] = '{8'h00, `CIOPL_P1_CLEAR_B,
        8'h00, 8'h00};

    function automatic logic [7:0] width_mask(input int w);
        width_mask = 8'((9'h001 << w) - 9'h001);
    endfunction

    // ------------------------------------------------------------
    // Drive decode
    // ------------------------------------------------------------
    // Drive decode for one pin from its mode and latch bit
    // Weak pull-up only in quasi mode; an outside low overrides it.
    // Strong high only in push-pull, so open-drain needs a pull-up.
    function automatic ciopl_pin_drive_t drive_of(input ciopl_mode_t m,
                                                  input logic l);
        ciopl_pin_drive_t d;
        d = '0;
        unique case (m)
            CIOPL_QUASI: begin
                d.strong_oe = ~l; // R5
                d.weak_pullup = l; // R5
            end
            CIOPL_PUSH_PULL: begin
                d.strong_oe = 1'b1; // R8
                d.strong_out = l; // R8
            end
            CIOPL_INPUT_ONLY: begin
                d = '0; // R7 R10
            end
            CIOPL_OPEN_DRAIN: begin
                d.strong_oe = ~l; // R6
            end
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Port latches and the two configuration planes
    logic [7:0] latch [4];
    logic [7:0] cfg_a [4];
    logic [7:0] cfg_b [4];

    // Port 0 digital input disable and user configuration byte
    logic [7:0] dig_in_dis;
    logic [7:0] user_cfg1;

    // Filtered pad levels, zero above each port's width
    logic [7:0] pin_val [4];

    // Captured address phase and slave state
    ciopl_ahb_req_t req;
    ciopl_bus_state_t state;
    ciopl_bus_state_t next_state;

    // ------------------------------------------------------------
    // AHB-Lite address and data phase decode
    // ------------------------------------------------------------
    // Only whole-word transfers are expected, so hsize is not decoded
    // haddr above bit 7 is not decoded, so the map repeats
    // A phase is taken only while the bus is ready
    wire ap_take = hsel && htrans[1] && hready;
    wire wr_phase = (state == CIOPL_ST_WRITE);
    wire in_port_block = (req.addr[7:6] == `CIOPL_PORT_BLOCK_SEL);
    wire [1:0] sel_port = req.addr[5:4];
    wire [1:0] sel_sub = req.addr[3:2];
    wire hit_dis = (req.addr == `CIOPL_OFS_DIG_IN_DIS);
    wire hit_ucfg = (req.addr == `CIOPL_OFS_USER_CFG1);
    wire [7:0] wdata = hwdata[7:0];

    // Writes land at the end of the data phase, at the captured address
    wire wr_latch = wr_phase && in_port_block
        && (sel_sub == `CIOPL_SUB_LATCH);
    wire wr_cfg_a = wr_phase && in_port_block
        && (sel_sub == `CIOPL_SUB_CFG_A);
    wire wr_cfg_b = wr_phase && in_port_block
        && (sel_sub == `CIOPL_SUB_CFG_B);
    wire wr_dis = wr_phase && hit_dis;
    wire wr_ucfg = wr_phase && hit_ucfg;

    // Reset pin function enable
    wire reset_pin_enable = user_cfg1[`CIOPL_RPE_BIT];

    // Masked write values; pinned port 1 bits keep their forced codes
    wire [7:0] wmask = width_mask(PW[sel_port]);
    wire [7:0] next_latch = wdata & wmask;
    wire [7:0] next_cfg_a = (wdata & wmask) | FORCE_A[sel_port]; // R3 R4
    wire [7:0] next_cfg_b = wdata & wmask & ~CLEAR_B[sel_port]; // R3

    // ------------------------------------------------------------
    // Read data select
    // ------------------------------------------------------------
    // Pins register is read-only; writes to it fall through
    // Read side: disabled port 0 inputs read as zero
    wire [7:0] pins_seen = pin_val[sel_port]
        & ~((sel_port == 2'h0) ? dig_in_dis : 8'h00); // R11
    wire [7:0] port_rd = (sel_sub == `CIOPL_SUB_LATCH) ? latch[sel_port]
        : (sel_sub == `CIOPL_SUB_CFG_A) ? cfg_a[sel_port]
        : (sel_sub == `CIOPL_SUB_CFG_B) ? cfg_b[sel_port]
        : pins_seen;
    wire [7:0] rd_mux = in_port_block ? port_rd
        : hit_dis ? dig_in_dis
        : hit_ucfg ? user_cfg1
        : 8'h00; // Unmapped reads return zero

    // ------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------
    // Reads take one wait state so that hrdata comes from a flop
    always_comb begin
        next_state = CIOPL_ST_IDLE;
        unique case (state)
            CIOPL_ST_RD_LOAD: begin
                next_state = CIOPL_ST_RD_DONE;
            end
            // A new phase may follow a write or the read's last cycle
            CIOPL_ST_IDLE, CIOPL_ST_WRITE, CIOPL_ST_RD_DONE: begin
                if (ap_take) begin
                    next_state = hwrite ? CIOPL_ST_WRITE : CIOPL_ST_RD_LOAD;
                end
            end
            default: begin
                next_state = CIOPL_ST_IDLE;
            end
        endcase
    end

    // Only the read load cycle waits; unmapped places still answer OKAY
    assign hreadyout = (state != CIOPL_ST_RD_LOAD);
    assign hresp = 1'b0;

    // State and captured address
    // Address held through the wait so the read select stays put
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= CIOPL_ST_IDLE;
            req <= '0;
        end else begin
            state <= next_state;
            if (ap_take) begin
                req <= '{addr: haddr[7:0], write: hwrite};
            end
        end
    end

    // Read data flop, loaded in the wait cycle
    // Writes leave it untouched, so it stands until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (state == CIOPL_ST_RD_LOAD) begin
            hrdata <= {24'h00_0000, rd_mux};
        end
    end

    // ------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------
    // Latches reset high, cut to each port's width
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < 4; p++) begin
                latch[p] <= `CIOPL_RST_LATCH & PMASK[p];
            end
        end else if (wr_latch) begin
            latch[sel_port] <= next_latch;
        end
    end

    // Configuration resets to input-only on every pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < 4; p++) begin
                cfg_a[p] <= `CIOPL_RST_CFG_A & PMASK[p]; // R13
            end
        end else if (wr_cfg_a) begin
            cfg_a[sel_port] <= next_cfg_a; // R2
        end
    end

    // Second plane; zero completes the input-only code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int p = 0; p < 4; p++) begin
                cfg_b[p] <= `CIOPL_RST_CFG_B & PMASK[p]; // R13
            end
        end else if (wr_cfg_b) begin
            cfg_b[sel_port] <= next_cfg_b; // R2
        end
    end

    // Digital input disable and user configuration
    // Only the documented bits are kept; the rest read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dig_in_dis <= `CIOPL_RST_DIG_IN_DIS; // R12
            user_cfg1 <= 8'(RPE_DEFAULT) << `CIOPL_RPE_BIT;
        end else begin
            if (wr_dis) begin
                dig_in_dis <= wdata & `CIOPL_DIG_IN_DIS_MASK; // R11
            end
            if (wr_ucfg) begin
                user_cfg1 <= wdata & `CIOPL_USER_CFG1_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Pads: per-pin drive and input conditioning
    // ------------------------------------------------------------
    // Pad drive is registered so the pads never see decode glitches
    // Filters reset high, the idle level of a pulled-up pad
    for (genvar p = 0; p < 4; p++) begin : g_port
        for (genvar b = 0; b < 8; b++) begin : g_bit
            if (b < PW[p]) begin : g_pin
                localparam int IDX = PBASE[p] + b;
                ciopl_mode_t mode;
                ciopl_pin_drive_t drv;
                logic clean;
                assign mode = ciopl_mode_t'({cfg_a[p][b], cfg_b[p][b]}); // R15
                assign drv = drive_of(mode, latch[p][b]); // R2

                ciopl_pin_filter #(
                    .FILTER_LEN(FILTER_LEN),
                    .RESET_LEVEL(1'b1)
                ) u_filter (
                    .hclk(hclk),
                    .hresetn(hresetn),
                    .pin_async(pin_in[IDX]),
                    .pin_clean(clean)
                ); // R9

                assign pin_val[p][b] = clean;

                // Drive flops reset to input-only
                always_ff @(posedge hclk or negedge hresetn) begin
                    if (!hresetn) begin
                        pin_oe[IDX] <= 1'b0; // R13
                        pin_out[IDX] <= 1'b0;
                        pin_weak_pullup[IDX] <= 1'b0;
                    end else begin
                        pin_oe[IDX] <= drv.strong_oe;
                        pin_out[IDX] <= drv.strong_out;
                        pin_weak_pullup[IDX] <= drv.weak_pullup;
                    end
                end
            end else begin : g_absent
                // Absent bits of narrow ports read zero
                assign pin_val[p][b] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Reset pin function
    // ------------------------------------------------------------
    // Filtered level keeps pad noise from resetting the chip
    wire rst_pin_level = pin_val[1][`CIOPL_P1_RESET_PIN];
    wire rst_pin_request = reset_pin_enable && !rst_pin_level; // R14

    // The power-up override of the enable is left to the chip reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_reset_n <= 1'b1;
        end else begin
            ext_reset_n <= ~rst_pin_request; // R14
        end
    end

endmodule // ciopl_port_logic

//--- tb/ciopl_pad_model.sv
// Pads and the outside circuits hanging on them.
// Assumes one bit per pin, indexed as the port logic's pin vectors.
`timescale 1ns/1ps
module ciopl_pad_model #(
    parameter int N = 23
) (
    input wire logic hclk,
    input wire logic [N-1:0] pin_oe,
    input wire logic [N-1:0] pin_out,
    input wire logic [N-1:0] pin_weak_pullup,
    input wire logic [N-1:0] ext_en,
    input wire logic [N-1:0] ext_val,
    output logic [N-1:0] pin_level
);
    logic [N-1:0] wander = '0;

    // Undriven pad wanders each cycle, so a stale level never passes
    always @(posedge hclk) begin
        wander <= ~wander;
    end

    // Strong driver wins, then the outside source, then the weak pull-up
    assign pin_level = (pin_oe & pin_out)
        | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_weak_pullup | wander));
endmodule // ciopl_pad_model

//--- tb/ciopl_port_logic_assertions.sv
// Checker of bus answer timing and pad drive of the port logic.
// Sees only the top module's ports; bound to it after the module.
`timescale 1ns/1ps
module ciopl_port_logic_checker #(
    parameter int PIN_COUNT = 23
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [PIN_COUNT-1:0] pin_in,
    input wire logic [PIN_COUNT-1:0] pin_out,
    input wire logic [PIN_COUNT-1:0] pin_oe,
    input wire logic [PIN_COUNT-1:0] pin_weak_pullup,
    input wire logic ext_reset_n
);
    // Address phases the slave takes
    wire logic rd_req = hsel && htrans[1] && hready && !hwrite;
    wire logic wr_req = hsel && htrans[1] && hready && hwrite;

    default clocking dcb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    read_wait_a: assert property (rd_req |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_nowait_a: assert property (wr_req |=> hreadyout)
        else $error("write stalled");
    rdata_upper_a: assert property (
        hreadyout && !$past(hreadyout) |-> hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    reset_input_only_a: assert property (
        $rose(hresetn) |-> pin_oe == '0 && pin_weak_pullup == '0)
        else $error("pin driven after reset");
    no_drive_fight_a: assert property (
        (pin_oe & pin_weak_pullup) == '0)
        else $error("weak and strong drive together");
    p1_bit5_input_a: assert property (
        !pin_oe[13] && !pin_weak_pullup[13])
        else $error("port 1 bit 5 driven");
    p1_od_only_a: assert property (
        (pin_weak_pullup[11:10] | (pin_oe[11:10] & pin_out[11:10])) == 2'h0)
        else $error("port 1 bit 2 or 3 drives high");
    out_after_write_a: assert property (
        $changed({pin_oe, pin_out, pin_weak_pullup})
        |-> $past(wr_req, 2) || $past(wr_req, 3))
        else $error("pad drive changed without a write");
    ext_reset_idle_a: assert property (
        pin_in[13] [*8] |-> ext_reset_n)
        else $error("reset request while pin high");
endmodule // ciopl_port_logic_checker

bind ciopl_port_logic ciopl_port_logic_checker #(
    .PIN_COUNT(PIN_COUNT)
) ciopl_port_logic_checker_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_weak_pullup(pin_weak_pullup),
    .ext_reset_n(ext_reset_n)
);

//--- tb/configurable_io_port_logic_tb.sv
// Bench of the port logic: AHB-Lite master, pad model, reference model.
// Assumes package, design, pad model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
        error_cnt++; \
        $display("wrong value %s exp %0h got %0h", nm, ex, got); \
    end \
end

module configurable_io_port_logic_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [22:0] ext_en = 23'h0;
    logic [22:0] ext_val = 23'h0;
    logic hreadyout, hresp, ext_reset_n;
    logic [31:0] hrdata;
    logic [22:0] pin_in, pin_out, pin_oe, pin_weak_pullup;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 32'hDA0DA43A;
    int lat[4], ca[4], cb[4], dis, ucfg;
    int wm[4] = '{8'hFF, 8'hFF, 8'h1F, 8'h03};
    int bs[4] = '{0, 8, 16, 21};

    // Free-running bus clock
    initial begin
        forever #10 hclk = ~hclk;
    end

    ciopl_port_logic ciopl_port_logic_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_weak_pullup(pin_weak_pullup),
        .ext_reset_n(ext_reset_n));
    ciopl_pad_model ciopl_pad_model_inst (
        .hclk(hclk), .pin_oe(pin_oe), .pin_out(pin_out),
        .pin_weak_pullup(pin_weak_pullup), .ext_en(ext_en),
        .ext_val(ext_val), .pin_level(pin_in));

    // ----------------
    // Bus master
    // ----------------
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) error_cnt++;
    endtask

    task automatic bus(input logic w, input int a, input int d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
    endtask

    // Write, and keep the reference model in step
    task automatic wr(input int a, input int d);
        logic [31:0] r;
        int p;
        bus(1'b1, a, d, r);
        p = a[5:4];
        d = d & 8'hFF;
        if (a == 8'h40) dis = d & 8'h3E;
        else if (a == 8'h44) ucfg = d & 8'h40;
        else if (a < 8'h40 && a[3:2] == 0) lat[p] = d & wm[p];
        else if (a < 8'h40 && a[3:2] == 1)
            ca[p] = (d & wm[p]) | (p == 1 ? 8'h2C : 0);
        else if (a < 8'h40 && a[3:2] == 2)
            cb[p] = d & wm[p] & (p == 1 ? 8'hDF : 8'hFF);
    endtask

    task automatic rdc(input int a, input int ex);
        logic [31:0] r;
        bus(1'b0, a, 0, r);
        `CHK($sformatf("reg %0h", a), ex, r)
    endtask

    // ----------------
    // Reference model
    // ----------------
    task automatic mreset;
        for (int p = 0; p < 4; p++) begin
            lat[p] = wm[p];
            ca[p] = wm[p];
            cb[p] = 0;
        end
        dis = 0;
        ucfg = 0;
    endtask

    task automatic chk_regs;
        for (int p = 0; p < 4; p++) begin
            rdc(p * 16, lat[p]);
            rdc(p * 16 + 4, ca[p]);
            rdc(p * 16 + 8, cb[p]);
        end
        rdc(8'h40, dis);
        rdc(8'h44, ucfg);
    endtask

    // Drive expected from latch and two code bits per pin
    task automatic chk_pins;
        logic [22:0] eo, eu, ew;
        int m, l, i;
        repeat (3) @(posedge hclk);
        for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (wm[p][b]) begin
                    i = bs[p] + b;
                    m = {ca[p][b], cb[p][b]};
                    l = lat[p][b];
                    eo[i] = (m == 1) || (m != 2 && !l);
                    eu[i] = (m == 1) && l;
                    ew[i] = (m == 0) && l;
                end
            end
        end
        `CHK("pin_oe", eo, pin_oe)
        `CHK("pin_out", eu, pin_out & pin_oe)
        `CHK("pin_weak_pullup", ew, pin_weak_pullup)
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        int p, m;
        mreset;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk_pins;
        chk_regs;
        for (m = 0; m < 4; m++) begin
            for (p = 0; p < 4; p++) begin
                wr(p * 16 + 4, m[1] ? 8'hFF : 8'h00);
                wr(p * 16 + 8, m[0] ? 8'hFF : 8'h00);
                wr(p * 16, $random(seed));
            end
            chk_pins;
            chk_regs;
        end
        repeat (8) begin
            p = $unsigned($random(seed)) % 4;
            wr(p * 16 + 4, $random(seed));
            wr(p * 16 + 8, $random(seed));
            wr(p * 16, $random(seed));
            chk_pins;
        end
        // Input path with all pins input-only, pads driven outside
        for (p = 0; p < 4; p++) begin
            wr(p * 16 + 4, 8'hFF);
            wr(p * 16 + 8, 8'h00);
        end
        ext_en <= 23'h7FFFFF;
        repeat (3) begin
            wr(8'h40, $random(seed));
            ext_val <= 23'($random(seed));
            repeat (12) @(posedge hclk);
            for (p = 0; p < 4; p++)
                rdc(p * 16 + 12, (ext_val >> bs[p]) & wm[p]
                    & (p == 0 ? ~dis : 8'hFF));
        end
        // One-cycle glitch is dropped, a held level passes
        ext_val <= 23'h0;
        repeat (12) @(posedge hclk);
        ext_val[16] <= 1'b1;
        @(posedge hclk);
        ext_val[16] <= 1'b0;
        repeat (12) @(posedge hclk);
        rdc(8'h2C, 0);
        ext_val[16] <= 1'b1;
        repeat (12) @(posedge hclk);
        rdc(8'h2C, 1);
        `CHK("ext_reset_n", 1'b1, ext_reset_n)
        wr(8'h44, 8'hFF);
        rdc(8'h44, ucfg);
        repeat (12) @(posedge hclk);
        `CHK("ext_reset_n", 1'b0, ext_reset_n)
        ext_val[13] <= 1'b1;
        repeat (12) @(posedge hclk);
        `CHK("ext_reset_n", 1'b1, ext_reset_n)
        // Unmapped and read-only places ignore writes
        wr(8'h80, 8'h5A);
        wr(8'h0C, 8'h5A);
        rdc(8'h80, 0);
        chk_regs;
        // Second reset in mid-run
        wr(8'h40, 8'hFF);
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        mreset;
        chk_pins;
        chk_regs;
        report_and_stop;
    end

    // Hang guard, well past the expected run length
    initial begin
        #400000;
        error_cnt++;
        report_and_stop;
    end
endmodule // configurable_io_port_logic_tb
